// File: rtl/ssl_pkg.sv
// Shared constants and carrier types for the status snapshot and interrupt latch.
package ssl_pkg;
  localparam int          SSL_NUM_RO    = 5;
  localparam int          SSL_WORD_W    = 16;
  localparam int          SSL_CAUSE_W   = 4;
  localparam int          SSL_PTR_W     = 3;
  localparam int          SSL_BIT_CNT_W = 5;
  localparam logic [7:0]  SSL_RD_ADDR   = 8'hC9;
  // Sub-address of the first read-only status register; the other four follow it.
  localparam logic [2:0]  SSL_PTR_C     = 3'h2;
  localparam logic [2:0]  SSL_PTR_RST   = 3'h0;
  localparam logic [15:0] SSL_SNAP_RST  = 16'h0000;
  localparam logic [3:0]  SSL_CAUSE_RST = 4'h0;
  // Serial bit slots: byte 0 in 0..7, release slot 8, byte 1 in 9..16, release from 17.
  localparam logic [4:0]  SSL_SLOT_ACK0 = 5'h08;
  localparam logic [4:0]  SSL_SLOT_END  = 5'h11;

  typedef struct packed {
    logic [SSL_NUM_RO-1:0][SSL_WORD_W-1:0] regs;
  } ssl_status_s;

  typedef struct packed {
    logic                   valid;
    logic [SSL_CAUSE_W-1:0] cause;
  } ssl_alarm_s;
endpackage : ssl_pkg

// File: rtl/ssl_shift.sv
// Serialiser that sends the captured word as two bytes, low byte first.
`timescale 1ns/100ps
module ssl_shift
  import ssl_pkg::*;
#(
  parameter int WORD_W = SSL_WORD_W
) (
  input  wire logic              i_clk,
  input  wire logic              i_srst,
  input  wire logic              i_load,
  input  wire logic [WORD_W-1:0] i_word,
  input  wire logic              i_adv,
  input  wire logic              i_stop,
  output logic                   o_sda_o,
  output logic                   o_sda_oe,
  output logic                   o_active
);
  // The slot map below assumes exactly two bytes per word.
  if (WORD_W != 16) begin : g_word_check
    $error("ssl_shift serves exactly two bytes");
  end

  logic [WORD_W-1:0]        sh_ff, nxt_sh;
  logic [SSL_BIT_CNT_W-1:0] cnt_ff, nxt_cnt;
  logic                     act_ff, nxt_act;
  logic                     oe_ff, nxt_oe;

  always_comb begin
    logic [SSL_BIT_CNT_W-1:0] idx;
    idx     = '0;
    nxt_sh  = sh_ff;
    nxt_cnt = cnt_ff;
    nxt_act = act_ff;
    nxt_oe  = oe_ff;
    if (i_stop) begin
      nxt_act = 1'b0;
      nxt_oe  = 1'b0;
    end else if (i_load) begin
      nxt_sh  = i_word;
      nxt_cnt = '0;
      nxt_act = 1'b1;
      nxt_oe  = ~i_word[0];
    end else if (i_adv && act_ff) begin
      nxt_cnt = cnt_ff + 5'h01;
      // Open drain: a one is sent by letting the line go, a zero by pulling it.
      if (nxt_cnt == SSL_SLOT_ACK0 || nxt_cnt >= SSL_SLOT_END) begin
        nxt_oe = 1'b0;
      end else begin
        idx    = (nxt_cnt < SSL_SLOT_ACK0) ? nxt_cnt : nxt_cnt - 5'h01;
        nxt_oe = ~sh_ff[idx[3:0]];
      end
      if (nxt_cnt >= SSL_SLOT_END) begin
        nxt_act = 1'b0;
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      sh_ff  <= '0;
      cnt_ff <= '0;
      act_ff <= 1'b0;
      oe_ff  <= 1'b0;
    end else begin
      sh_ff  <= nxt_sh;
      cnt_ff <= nxt_cnt;
      act_ff <= nxt_act;
      oe_ff  <= nxt_oe;
    end
  end

  assign o_sda_o  = 1'b0;
  assign o_sda_oe = oe_ff;
  assign o_active = act_ff;
endmodule : ssl_shift

// File: rtl/ssl_latch.sv
// Status snapshot, interrupt cause latch and read-out path of the battery monitor.
// Overview of operation
// - Status reads return data from one instant.
// - Not busy: sample at read-address acknowledge.
// - Busy at acknowledge: report last completed result.
// - Alarm drives interrupt low, latches four causes.
// - Pending request shows latched cause bits in reads of the first status register; a new alarm overwrites them.
// - Clearing request clears and unfreezes cause bits.
// - After clear, first update event refreshes snapshot.
// - Send two bytes low first, then release line.
// - Read address byte is acknowledged before data.
// - Written pointer persists and selects later reads.
`timescale 1ns/100ps
module ssl_latch
  import ssl_pkg::*;
(
  input  wire logic                 I_CORE_CLK,
  input  wire logic                 I_SRST,
  input  wire logic                 I_PTR_WR,
  input  wire logic [SSL_PTR_W-1:0] I_PTR,
  input  wire logic                 I_RD_ADDR_ACK,
  input  wire logic                 I_BIT_ADV,
  input  wire logic                 I_BUS_STOP,
  input  wire ssl_status_s          I_LIVE,
  input  wire logic                 I_CONV_BUSY,
  input  wire logic                 I_CONV_DONE,
  input  wire logic                 I_PEAK_BUSY,
  input  wire logic                 I_PEAK_END,
  input  wire ssl_alarm_s           I_ALARM,
  input  wire logic                 I_IRQ_CLR,
  output logic                      O_IRQ_N,
  output logic                      O_SDA_O,
  output logic                      O_SDA_OE,
  output logic                      O_READ_ACTIVE
);
  logic [SSL_PTR_W-1:0]   ptr_ff, nxt_ptr;
  ssl_status_s            snap_ff, nxt_snap;
  logic                   pend_ff, nxt_pend;
  logic [SSL_CAUSE_W-1:0] cause_ff, nxt_cause;
  logic                   irq_n_ff, nxt_irq_n;
  logic                   busy;
  logic                   take;
  logic [SSL_WORD_W-1:0]  rd_word;

  always_comb begin
    logic [SSL_PTR_W-1:0] idx;
    idx       = '0;
    busy      = I_CONV_BUSY | I_PEAK_BUSY;
    nxt_ptr   = I_PTR_WR ? I_PTR : ptr_ff;
    // A read during a conversion or peak pulse keeps the snapshot, which already
    // holds the previous result, instead of sampling half-updated values.
    take      = (I_RD_ADDR_ACK & ~busy) | I_CONV_DONE | I_PEAK_END | I_ALARM.valid;
    nxt_snap  = take ? I_LIVE : snap_ff;
    nxt_pend  = pend_ff;
    nxt_cause = cause_ff;
    if (I_IRQ_CLR) begin
      nxt_pend  = 1'b0;
      nxt_cause = SSL_CAUSE_RST;
    end
    // An alarm in the clear cycle wins so that no event is lost.
    if (I_ALARM.valid) begin
      nxt_pend  = 1'b1;
      nxt_cause = I_ALARM.cause;
    end
    nxt_irq_n = ~nxt_pend;
    idx       = nxt_ptr - SSL_PTR_C;
    rd_word   = '0;
    if (nxt_ptr >= SSL_PTR_C && idx < 3'(SSL_NUM_RO)) begin
      rd_word = nxt_snap.regs[idx];
      if (idx == 3'h0 && nxt_pend) begin
        rd_word[SSL_CAUSE_W-1:0] = nxt_cause;
      end
    end
  end

  always_ff @(posedge I_CORE_CLK) begin
    if (I_SRST) begin
      ptr_ff   <= SSL_PTR_RST;
      snap_ff  <= {SSL_NUM_RO{SSL_SNAP_RST}};
      pend_ff  <= 1'b0;
      cause_ff <= SSL_CAUSE_RST;
      irq_n_ff <= 1'b1;
    end else begin
      ptr_ff   <= nxt_ptr;
      snap_ff  <= nxt_snap;
      pend_ff  <= nxt_pend;
      cause_ff <= nxt_cause;
      irq_n_ff <= nxt_irq_n;
    end
  end

  assign O_IRQ_N = irq_n_ff;

  // Loading on the acknowledge pulse means data only follows the acknowledge.
  ssl_shift #(
    .WORD_W (SSL_WORD_W)
  ) u_shift (
    .i_clk    (I_CORE_CLK),
    .i_srst   (I_SRST),
    .i_load   (I_RD_ADDR_ACK),
    .i_word   (rd_word),
    .i_adv    (I_BIT_ADV),
    .i_stop   (I_BUS_STOP),
    .o_sda_o  (O_SDA_O),
    .o_sda_oe (O_SDA_OE),
    .o_active (O_READ_ACTIVE)
  );

  default clocking cb @(posedge I_CORE_CLK); endclocking
  default disable iff (I_SRST);

  AST_SNAP_AT_ACK: assert property (
    I_RD_ADDR_ACK && !busy |=> snap_ff == $past(I_LIVE))
    else $error("Snapshot not taken at read acknowledge");
  AST_HOLD_BUSY: assert property (
    I_RD_ADDR_ACK && busy && !I_CONV_DONE && !I_PEAK_END && !I_ALARM.valid |=> $stable(snap_ff))
    else $error("Snapshot changed during busy acknowledge");
  AST_IRQ_LATCH: assert property (
    I_ALARM.valid |=> !O_IRQ_N && cause_ff == $past(I_ALARM.cause))
    else $error("Alarm did not assert interrupt with causes");
  AST_FROZEN: assert property (
    pend_ff && !I_ALARM.valid && !I_IRQ_CLR |=> $stable(cause_ff) && !O_IRQ_N)
    else $error("Cause bits moved while request pending");
  AST_CLEAR: assert property (
    I_IRQ_CLR && !I_ALARM.valid |=> O_IRQ_N && cause_ff == SSL_CAUSE_RST)
    else $error("Clear did not release interrupt and causes");
  AST_UPDATE: assert property (
    I_CONV_DONE || I_PEAK_END |=> snap_ff == $past(I_LIVE))
    else $error("Snapshot not updated on measurement event");
  AST_PTR_KEEP: assert property (
    !I_PTR_WR |=> $stable(ptr_ff))
    else $error("Pointer changed without a write");
  AST_FIRST_BIT: assert property (
    I_RD_ADDR_ACK && !I_BUS_STOP |=> O_SDA_OE == !$past(rd_word[0]) && O_READ_ACTIVE)
    else $error("First data bit not driven after acknowledge");
  AST_CAUSE_READ: assert property (
    I_RD_ADDR_ACK && !I_BUS_STOP && pend_ff && ptr_ff == SSL_PTR_C && !I_PTR_WR && !I_ALARM.valid && !I_IRQ_CLR
    |=> O_SDA_OE == !cause_ff[0])
    else $error("Frozen cause bit not sent on status read");
  AST_STOP_ABORT: assert property (
    I_BUS_STOP |=> !O_READ_ACTIVE && !O_SDA_OE)
    else $error("Stop did not abort the read-out");
  AST_IDLE_RELEASED: assert property (
    !O_READ_ACTIVE |-> !O_SDA_OE)
    else $error("Data line pulled outside a read-out");
  AST_NO_EARLY_DATA: assert property (
    !O_READ_ACTIVE && !I_RD_ADDR_ACK |=> !O_READ_ACTIVE)
    else $error("Read-out started without an acknowledge");
endmodule : ssl_latch

// File: tb/ssl_master.sv
// Bus master model that drives the engine-side strobes and collects read data.
`timescale 1ns/100ps
module ssl_master (
  input  wire logic       i_clk,
  input  wire logic       i_oe,
  output logic            o_wr,
  output logic [2:0]      o_ptr,
  output logic            o_ack,
  output logic            o_adv,
  output logic            o_stop,
  output logic            o_clr
);
  // A single device sits on this bus, so no select logic is needed.
  initial {o_wr, o_ptr, o_ack, o_adv, o_stop, o_clr} = '0;
  task automatic wp(input logic [2:0] p);
    o_wr = 1'b1;
    o_ptr = p;
    @(posedge i_clk);
    #1 o_wr = 1'b0;
  endtask : wp
  task automatic hit(input logic [1:0] k);
    {o_stop, o_clr} = k;
    @(posedge i_clk);
    #1 {o_stop, o_clr} = 2'b00;
  endtask : hit
  // Slot 8 is the master's acknowledge slot, so the line must be free there.
  task automatic rd(output logic [15:0] w, output logic rel);
    o_ack = 1'b1;
    @(posedge i_clk);
    #1 o_ack = 1'b0;
    rel = 1'b1;
    for (int s = 0; s < 17; s++) begin
      if (s == 8) rel &= !i_oe;
      else w[s - (s > 8)] = ~i_oe;
      o_adv = 1'b1;
      @(posedge i_clk);
      #1 o_adv = 1'b0;
    end
    rel &= !i_oe;
  endtask : rd
endmodule : ssl_master

// File: tb/ssl_latch_tb.sv
// Self-checking testbench for the status snapshot and interrupt latch.
`timescale 1ns/100ps
module ssl_latch_tb;
  import ssl_pkg::*;
  logic        clk, srst, cb, cd, pb, pe, irq_n, sda_o, oe, act, rel;
  logic        wr, ack, adv, stp, clr;
  logic [2:0]  ptr;
  logic [15:0] w;
  ssl_status_s live;
  ssl_alarm_s  alarm;
  int          fail_count = 0;
  int          checks = 0;
  ssl_latch uut (.I_CORE_CLK(clk), .I_SRST(srst), .I_PTR_WR(wr), .I_PTR(ptr), .I_RD_ADDR_ACK(ack),
    .I_BIT_ADV(adv), .I_BUS_STOP(stp), .I_LIVE(live), .I_CONV_BUSY(cb), .I_CONV_DONE(cd),
    .I_PEAK_BUSY(pb), .I_PEAK_END(pe), .I_ALARM(alarm), .I_IRQ_CLR(clr), .O_IRQ_N(irq_n),
    .O_SDA_O(sda_o), .O_SDA_OE(oe), .O_READ_ACTIVE(act));
  ssl_master m (.i_clk(clk), .i_oe(oe), .o_wr(wr), .o_ptr(ptr), .o_ack(ack), .o_adv(adv),
    .o_stop(stp), .o_clr(clr));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic end_sim;
    $display("Checks %0d, errors %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : end_sim
  task automatic t_read;
    live.regs[1] = 16'hA55A;
    m.wp(3'h3);
    m.rd(w, rel);
    chk(w, 16'hA55A);
    chk({act, rel}, 16'h0001);
    live.regs[1] = 16'h1234;
    m.rd(w, rel);
    chk(w, 16'h1234);
    // The live word moves mid-transfer; the sent word must not.
    fork
      m.rd(w, rel);
      begin
        repeat (3) @(posedge clk);
        #1 live.regs[1] = 16'hFFFF;
      end
    join
    chk(w, 16'h1234);
    m.rd(w, rel);
    chk(w, 16'hFFFF);
  endtask : t_read
  task automatic t_busy;
    logic [15:0] prev;
    prev = 16'hFFFF;
    for (int k = 0; k < 2; k++) begin
      {pb, cb} = 2'b01 << k;
      live.regs[1] = 16'h0B00;
      m.rd(w, rel);
      chk(w, prev);
      live.regs[1] = 16'h0C0C + 16'(k);
      {pe, cd} = 2'b01 << k;
      @(posedge clk);
      #1 {pe, cd} = 2'b00;
      live.regs[1] = 16'h0D0D;
      prev = 16'h0C0C + 16'(k);
      m.rd(w, rel);
      chk(w, prev);
      {pb, cb} = 2'b00;
    end
  endtask : t_busy
  task automatic t_irq;
    m.wp(3'h2);
    live.regs[0] = 16'h1235;
    alarm = '{1'b1, 4'hA};
    @(posedge clk);
    #1 alarm.valid = 1'b0;
    chk({15'h0, irq_n}, 16'h0000);
    live.regs[0] = 16'h4321;
    m.rd(w, rel);
    chk(w, 16'h432A);
    m.hit(2'b01);
    chk({15'h0, irq_n}, 16'h0001);
    m.rd(w, rel);
    chk(w, 16'h4321);
    // A stop after three bits abandons the word; the line reads released.
    fork
      m.rd(w, rel);
      begin
        repeat (3) @(posedge clk);
        #1 m.hit(2'b10);
      end
    join
    chk(w, 16'hFFF9);
    chk({15'h0, act}, 16'h0000);
    // Alarm and clear in one cycle: the alarm must win with its new causes.
    alarm = '{1'b1, 4'h5};
    m.hit(2'b01);
    alarm.valid = 1'b0;
    chk({15'h0, irq_n}, 16'h0000);
    m.rd(w, rel);
    chk(w, 16'h4325);
    m.hit(2'b01);
    chk({15'h0, irq_n}, 16'h0001);
    // A pointer outside the status range reads as zero.
    m.wp(3'h0);
    m.rd(w, rel);
    chk(w, 16'h0000);
  endtask : t_irq
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    #200000;
    fail_count++;
    end_sim();
  end
  initial begin
    {srst, cb, cd, pb, pe} = 5'b10000;
    live = '0;
    alarm = '0;
    repeat (4) @(posedge clk);
    #1 srst = 1'b0;
    chk({irq_n, oe, act, sda_o}, 16'h0008);
    t_read();
    t_busy();
    t_irq();
    end_sim();
  end
endmodule : ssl_latch_tb
